// file: src/gcl_defines.svh
// timing constants and mode encodings for the line timing block
`ifndef GCL_DEFINES_SVH
`define GCL_DEFINES_SVH
`define GCL_REF_HZ 100000000
`define GCL_LINE_BPS 64000
`define GCL_OCTET_HZ 8000
`define GCL_BIT_CYC (`GCL_REF_HZ / `GCL_LINE_BPS)
`define GCL_BIT_CNT_W 11
`define GCL_OCTET_BITS 8
`define GCL_OCTET_MARK_BIT 3'h7
`define GCL_FIFO_WIDTH 1
`define GCL_FIFO_DEPTH 8
`define GCL_MODE_LOOP 2'h0
`define GCL_MODE_INT 2'h1
`define GCL_MODE_MINLB 2'h2
`define GCL_MODE_DUAL 2'h3
`define GCL_DFLT_OCTET 1'h1
`define GCL_DFLT_MODE 2'h0
`endif

// file: src/gcl_pkg.sv
// types shared by the line timing block
package gcl_pkg;
  typedef enum logic [1:0]
  {
    GCL_LOOP = 2'b00,
    GCL_INTERNAL = 2'b01,
    GCL_MIN_LOOPBACK = 2'b10,
    GCL_DUAL_LOOPBACK = 2'b11
  } gcl_mode_t;
endpackage

// file: src/gcl_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module gcl_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic doWr;
  logic doRd;

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (ce && doWr)
    begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else if (ce)
    begin
      if (doWr)
      begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (doRd)
      begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      if (doWr && !doRd)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (doRd && !doWr)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// file: src/gcl_channel.sv
// one 64 kbps line channel: timing mode, octet marking and loopback steering
`timescale 1ns/100ps
`include "gcl_defines.svh"
module gcl_channel
  import gcl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic lineClk,
  input wire logic lineRxData,
  output logic lineTxData,
  output logic lineTxOctet,
  output logic lineTxBitClk,
  input wire logic octet_timing_switch,
  input wire logic mode_switch_low,
  input wire logic mode_switch_high,
  input wire logic inRxData,
  input wire logic inRxValid,
  output logic inRxReady,
  output logic inTxData,
  output logic inTxValid,
  input wire logic inTxReady,
  output gcl_pkg::gcl_mode_t modeNow,
  output logic octetEnNow
);
  // ---------------- line clock domain ----------------
  logic rxLatch_r;
  logic lineRstS1_r;
  logic lineRst_r;
  logic rxTgl_r;

  // reset into the line domain
  always_ff @(posedge lineClk)
  begin
    lineRstS1_r <= rst;
    lineRst_r <= lineRstS1_r;
  end

  // stabilisation latch on received line data
  always_ff @(posedge lineClk)
  begin
    if (lineRst_r)
    begin
      rxLatch_r <= 1'b0;
      rxTgl_r <= 1'b0;
    end
    else
    begin
      rxLatch_r <= lineRxData;
      rxTgl_r <= ~rxTgl_r;
    end
  end

  // ---------------- reference domain ----------------
  logic [1:0] modeSw1_r;
  logic [1:0] modeSw2_r;
  logic octSw1_r;
  logic octSw2_r;
  logic strapDone_r;
  logic octetEn_r;
  gcl_mode_t mode_r;
  logic rxD1_r;
  logic rxD2_r;
  logic rxT1_r;
  logic rxT2_r;
  logic rxT3_r;
  logic rxEdge;
  logic [`GCL_BIT_CNT_W-1:0] bitCnt_r;
  logic intTick;
  logic txTick;
  logic [2:0] bitIdx_r;
  logic txData_r;
  logic txOctet_r;
  logic txBitClk_r;
  logic inTxData_r;
  logic inTxValid_r;
  logic fifoData;
  logic fifoValid;
  logic fifoReady;
  logic fifoInValid;
  logic fifoInData;
  logic fifoInReady;

  function automatic gcl_mode_t decodeMode(input logic [1:0] sw);
    case (sw)
      2'b00: decodeMode = GCL_LOOP;
      2'b01: decodeMode = GCL_INTERNAL;
      2'b10: decodeMode = GCL_MIN_LOOPBACK;
      2'b11: decodeMode = GCL_DUAL_LOOPBACK;
      default: decodeMode = GCL_LOOP;
    endcase
  endfunction

  // strap synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (ce)
    begin
      modeSw1_r <= {mode_switch_high, mode_switch_low};
      modeSw2_r <= modeSw1_r;
      octSw1_r <= octet_timing_switch;
      octSw2_r <= octSw1_r;
    end
  end

  // straps caught once after reset release, then frozen
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      strapDone_r <= 1'b0;
      octetEn_r <= `GCL_DFLT_OCTET;
      mode_r <= gcl_mode_t'(`GCL_DFLT_MODE);
    end
    else if (ce && !strapDone_r)
    begin
      strapDone_r <= 1'b1;
      octetEn_r <= octSw2_r;
      mode_r <= decodeMode(modeSw2_r);
    end
  end

  assign modeNow = mode_r;
  assign octetEnNow = octetEn_r;

  // received data and line clock events into the reference domain
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rxD1_r <= 1'b0;
      rxD2_r <= 1'b0;
      rxT1_r <= 1'b0;
      rxT2_r <= 1'b0;
      rxT3_r <= 1'b0;
    end
    else if (ce)
    begin
      rxD1_r <= rxLatch_r;
      rxD2_r <= rxD1_r;
      rxT1_r <= rxTgl_r;
      rxT2_r <= rxT1_r;
      rxT3_r <= rxT2_r;
    end
  end

  assign rxEdge = rxT2_r ^ rxT3_r;

  // local 64 kbps bit timer
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bitCnt_r <= '0;
    end
    else if (ce)
    begin
      if (bitCnt_r == `GCL_BIT_CNT_W'(`GCL_BIT_CYC - 1))
      begin
        bitCnt_r <= '0;
      end
      else
      begin
        bitCnt_r <= bitCnt_r + 1'b1;
      end
    end
  end

  assign intTick = (bitCnt_r == '0);
  // internal timing uses local timer, every other mode follows the line
  assign txTick = (mode_r == GCL_INTERNAL) ? intTick : rxEdge;

  // fifo feeds inside receive data toward the line transmitter
  assign fifoInData = inRxData;
  assign fifoInValid = inRxValid && (mode_r != GCL_DUAL_LOOPBACK);
  assign inRxReady = (mode_r == GCL_DUAL_LOOPBACK) ? inTxReady || !inTxValid_r : fifoInReady;
  assign fifoReady = ce && txTick;

  gcl_fifo #(
    .WIDTH(`GCL_FIFO_WIDTH),
    .DEPTH(`GCL_FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .inData(fifoInData),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoReady)
  );

  // line transmit bit and octet position
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bitIdx_r <= '0;
      txData_r <= 1'b0;
      txOctet_r <= 1'b0;
      txBitClk_r <= 1'b0;
    end
    else if (ce)
    begin
      txBitClk_r <= txTick;
      if (txTick)
      begin
        bitIdx_r <= bitIdx_r + 1'b1;
        txOctet_r <= octetEn_r && (bitIdx_r == `GCL_OCTET_MARK_BIT);
        case (mode_r)
          GCL_MIN_LOOPBACK: txData_r <= rxD2_r;
          GCL_DUAL_LOOPBACK: txData_r <= rxD2_r;
          default: txData_r <= fifoValid ? fifoData : 1'b1;
        endcase
      end
    end
  end

  // inside transmitter: line data, or inside data in dual loopback
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      inTxData_r <= 1'b0;
      inTxValid_r <= 1'b0;
    end
    else if (ce)
    begin
      if (mode_r == GCL_DUAL_LOOPBACK)
      begin
        if (inRxValid && inRxReady)
        begin
          inTxData_r <= inRxData;
          inTxValid_r <= 1'b1;
        end
        else if (inTxReady)
        begin
          inTxValid_r <= 1'b0;
        end
      end
      // a held word is never overwritten while the inside sink stalls
      else if (rxEdge && (!inTxValid_r || inTxReady))
      begin
        inTxData_r <= rxD2_r;
        inTxValid_r <= 1'b1;
      end
      else if (inTxReady)
      begin
        inTxValid_r <= 1'b0;
      end
    end
  end

  assign lineTxData = txData_r;
  assign lineTxOctet = txOctet_r;
  assign lineTxBitClk = txBitClk_r;
  assign inTxData = inTxData_r;
  assign inTxValid = inTxValid_r;
endmodule

// file: verification/gcl_chk_sva.sv
// port assertions for the line timing channel
`timescale 1ns/100ps
`include "gcl_defines.svh"
module gcl_chk
  import gcl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic lineClk,
  input wire logic lineTxData,
  input wire logic lineTxOctet,
  input wire logic lineTxBitClk,
  input wire logic inRxValid,
  input wire logic inRxReady,
  input wire logic inTxData,
  input wire logic inTxValid,
  input wire logic inTxReady,
  input wire gcl_pkg::gcl_mode_t modeNow,
  input wire logic octetEnNow
);
  import gcl_pkg::*;
  localparam int GAP = `GCL_BIT_CYC - 1;
  logic [5:0] up_r;
  logic [11:0] gap_r;
  logic intPrev_r;
  // settle time after reset, covers the line-side reset sync
  always_ff @(posedge ref_clk)
    if (rst) up_r <= 6'h0;
    else if (up_r != 6'h3f) up_r <= up_r + 6'h1;
  always_ff @(posedge ref_clk)
    if (rst || lineTxBitClk) gap_r <= 12'h0;
    else gap_r <= gap_r + 12'h1;
  always_ff @(posedge ref_clk)
    if (rst) intPrev_r <= 1'h0;
    else if (lineTxBitClk) intPrev_r <= (modeNow == GCL_INTERNAL);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence edge_s;
    $rose(lineClk) && modeNow != GCL_INTERNAL && up_r == 6'h3f;
  endsequence
  chk_pulse_one: assert property (lineTxBitClk |=> !lineTxBitClk)
    else $error("bit clock pulse too long");
  chk_reset_dflt: assert property (disable iff (1'b0) rst |=> modeNow == GCL_LOOP && octetEnNow)
    else $error("wrong default straps");
  chk_mode_held: assert property (up_r == 6'h3f |-> $stable(modeNow) && $stable(octetEnNow))
    else $error("mode changed in operation");
  chk_octet_off: assert property (up_r == 6'h3f && !octetEnNow |-> !lineTxOctet)
    else $error("octet mark while disabled");
  chk_tx_steady: assert property (up_r == 6'h3f && !lineTxBitClk |-> $stable(lineTxData) && $stable(lineTxOctet))
    else $error("line bit moved between ticks");
  chk_int_period: assert property (lineTxBitClk && intPrev_r && modeNow == GCL_INTERNAL |-> gap_r == GAP)
    else $error("internal bit period wrong");
  chk_line_tick: assert property (edge_s |-> ##[1:8] lineTxBitClk)
    else $error("line tick not following line clock");
  chk_txv_hold: assert property (inTxValid && !inTxReady |=> inTxValid && $stable(inTxData))
    else $error("inside tx dropped while stalled");
  chk_dual_pass: assert property (modeNow == GCL_DUAL_LOOPBACK && inRxValid && inRxReady |-> ##[1:4] inTxValid)
    else $error("dual loopback inside path stuck");
endmodule
bind gcl_channel gcl_chk chk (.ref_clk(ref_clk), .rst(rst), .lineClk(lineClk),
  .lineTxData(lineTxData), .lineTxOctet(lineTxOctet), .lineTxBitClk(lineTxBitClk),
  .inRxValid(inRxValid), .inRxReady(inRxReady), .inTxData(inTxData), .inTxValid(inTxValid),
  .inTxReady(inTxReady), .modeNow(modeNow), .octetEnNow(octetEnNow));

// file: verification/gcl_line_peer.sv
// far line end: runs the 80 ns line clock and sends a steady line bit
`timescale 1ns/100ps
module gcl_line_peer (
  input wire logic lineBit,
  output logic lineClk,
  output logic lineRxData
);
  initial
  begin
    lineClk = 1'h0;
    lineRxData = 1'h0;
    #3;
    forever #40 lineClk = ~lineClk;
  end
  // far end supplies line timing, data moves away from the sampling edge
  always @(negedge lineClk) lineRxData <= lineBit;
endmodule

// file: verification/tb.sv
// self-checking bench for one line channel
`timescale 1ns/100ps
module tb;
  import gcl_pkg::*;
  logic ref_clk, rst, lineClk, lineRxData, lineBit, ltx, oct, bclk, lastTx;
  logic sw0, sw1, sw2, irD, irV, irR, itD, itV, itR, octEn;
  gcl_mode_t mode;
  int err_total, num_checks, marks, w;
  // oct low high | mode | line tx, inside tx | octet marks in 16 bits
  logic [8:0] rows [4] = '{9'b100_00_01_10, 9'b010_01_01_00,
    9'b001_10_11_00, 9'b011_11_10_00};
  gcl_channel dut (.ref_clk(ref_clk), .rst(rst), .ce(1'h1), .lineClk(lineClk),
    .lineRxData(lineRxData), .lineTxData(ltx), .lineTxOctet(oct), .lineTxBitClk(bclk),
    .octet_timing_switch(sw0), .mode_switch_low(sw1), .mode_switch_high(sw2),
    .inRxData(irD), .inRxValid(irV), .inRxReady(irR), .inTxData(itD),
    .inTxValid(itV), .inTxReady(itR), .modeNow(mode), .octetEnNow(octEn));
  gcl_line_peer peer (.lineBit(lineBit), .lineClk(lineClk), .lineRxData(lineRxData));
  task automatic chk(string n, logic [2:0] e, logic [2:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // line domain needs several of its own edges inside reset
  task automatic reset_dut;
    @(posedge ref_clk) #1 rst = 1'h1;
    repeat (30) @(posedge ref_clk);
    #1 rst = 1'h0;
  endtask
  task automatic bits(input int n);
    marks = 0;
    repeat (n)
    begin
      w = 0;
      do @(posedge ref_clk) #1 w++;
      while (bclk !== 1'h1 && w < 2000);
      err_total += (w >= 2000);
      if (oct === 1'h1) marks++;
      else lastTx = ltx;
    end
  endtask
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #600000;
    err_total++;
    stop_test();
  end
  // inside sink stalls every other cycle
  always @(posedge ref_clk) itR <= #1 ~itR;
  initial
  begin
    {rst, sw0, sw1, sw2, irD, irV, itR, lineBit} = 8'b1011_0001;
    err_total = 0;
    num_checks = 0;
    repeat (30) @(posedge ref_clk);
    #1 chk("reset mode", {GCL_LOOP, 1'h1}, {mode, octEn});
    chk("reset tx", 3'h0, {ltx, oct, bclk});
    foreach (rows[i])
    begin
      {sw0, sw1, sw2} = rows[i][8:6];
      irV = 1'h1;
      reset_dut();
      bits(4);
      chk("mode", {rows[i][5:4], rows[i][8]}, {mode, octEn});
      bits(16);
      chk("octets", {1'h0, rows[i][1:0]}, marks[2:0]);
      chk("line tx", {2'h0, rows[i][3]}, {2'h0, lastTx});
      chk("inside tx", {2'h0, rows[i][2]}, {2'h0, itD});
      $display("row %0d done", i);
    end
    {sw0, sw1, sw2} = 3'b100;
    reset_dut();
    {sw1, sw2} = 2'b11;
    w = 0;
    while (irR !== 1'h0 && w < 5000) @(posedge ref_clk) #1 w++;
    chk("refused", 3'h0, {2'h0, irR});
    do @(posedge ref_clk) #1;
    while (irR !== 1'h1);
    irV = 1'h0;
    bits(12);
    chk("idle", 3'h1, {2'h0, lastTx});
    chk("held", {GCL_LOOP, 1'h1}, {mode, octEn});
    $display("fifo test done");
    stop_test();
  end
endmodule
